// *** core/otp_access_ctrl.v ***
// Serial instruction front end for secured OTP mode and security flags
`include "otp_access_regs.vh"

module otp_access_ctrl (
	input wire CORE_CLK,
	input wire RST,
	input wire SCK,
	input wire CS_N,
	input wire SI,
	input wire FACTORY_LOCK,
	output reg SO,
	output reg SO_OE_N,
	output reg OTP_MODE,
	output reg [7:0] SEC_FLAGS,
	output reg [7:0] CMD_OPCODE,
	output reg CMD_STROBE,
	output reg CMD_REFUSED
);
	localparam ST_OP = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_DUMMY = 3'h2;
	localparam ST_DATA_IN = 3'h3;
	localparam ST_DATA_OUT = 3'h4;
	localparam ST_IGNORE = 3'h5;

	reg sck_s1, sck_s2, sck_d;
	reg cs_s1, cs_s2, cs_d;
	reg si_s1, si_s2;
	reg fl_s1, factory;
	reg [2:0] phase;
	reg [2:0] bit_cnt;
	reg [2:0] byte_cnt;
	reg [6:0] shift;
	reg [7:0] opcode;
	reg [23:0] addr;
	reg [7:0] out_shift;
	reg [7:0] wsec_data;
	reg load_pending;
	reg otp_lockdown_bit;
	reg wel;
	reg otp_wr;
	reg [`OTP_AW-1:0] otp_waddr;
	reg [7:0] otp_wdata;
	wire [7:0] otp_rdata;
	wire [7:0] next_byte;
	wire sck_rise;
	wire sck_fall;
	wire cs_rise;
	wire locked;
	wire otp_in_range;
	wire [7:0] sec_value;
	wire refuse;

	// Read-type instructions still valid after lock-down
	function is_read;
		input [7:0] op;
		begin
			is_read = (op == `OP_READ) || (op == `OP_FAST_READ) ||
				(op == `OP_READ_SEC) || (op == `OP_READ_SFDP) ||
				(op == `OP_READ_SR1) || (op == `OP_READ_SR2) ||
				(op == `OP_READ_ID);
		end
	endfunction

	function is_array_write;
		input [7:0] op;
		begin
			is_array_write = (op == `OP_PROGRAM) ||
				(op == `OP_QPROGRAM) || (op == `OP_ERASE_4K) ||
				(op == `OP_ERASE_32K) || (op == `OP_ERASE_64K) ||
				(op == `OP_ERASE_CHIP1) || (op == `OP_ERASE_CHIP2);
		end
	endfunction

	function [7:0] sfdp_byte;
		input [7:0] a;
		begin
			case (a)
				`SFDP_ADDR_68: sfdp_byte = `SFDP_DATA_68;
				`SFDP_ADDR_69: sfdp_byte = `SFDP_DATA_69;
				`SFDP_ADDR_6A: sfdp_byte = {`SFDP_HOLD_RST_DIS,
					`SFDP_QUAD_ENABLE_REQUIREMENT,
					`SFDP_LOW_6A};
				default: sfdp_byte = `SFDP_FILL;
			endcase
		end
	endfunction

	assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
	assign cs_rise = cs_s2 & ~cs_d;
	assign next_byte = {shift, si_s2};
	// Factory lock counts as lock-down as well
	assign locked = otp_lockdown_bit | factory;
	assign otp_in_range = (addr[23:`OTP_AW] == 15'h0000);
	assign sec_value = {`SEC_RSVD_ZERO, otp_lockdown_bit,
		factory};
	assign refuse = OTP_MODE & (
		(next_byte == `OP_WRITE_SR1) || (next_byte == `OP_WRITE_SR2) ||
		(next_byte == `OP_WRITE_SEC) ||
		(locked && !is_read(next_byte) &&
			next_byte != `OP_EXIT_OTP) ||
		(is_array_write(next_byte) && !(next_byte == `OP_PROGRAM &&
			!locked && wel)));

	otp_store u_store (
		.clk(CORE_CLK),
		.wr_en(otp_wr),
		.waddr(otp_waddr),
		.wdata(otp_wdata),
		.raddr(addr[`OTP_AW-1:0]),
		.rdata(otp_rdata)
	);

	always @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_d <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_d <= 1'b1;
			si_s1 <= 1'b0;
			si_s2 <= 1'b0;
			fl_s1 <= 1'b0;
			factory <= 1'b0;
			phase <= ST_OP;
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			shift <= 7'h00;
			opcode <= 8'h00;
			addr <= 24'h000000;
			out_shift <= 8'h00;
			wsec_data <= 8'h00;
			load_pending <= 1'b0;
			otp_lockdown_bit <= 1'b0;
			wel <= 1'b0;
			otp_wr <= 1'b0;
			otp_waddr <= {`OTP_AW{1'b0}};
			otp_wdata <= 8'h00;
			SO <= 1'b0;
			SO_OE_N <= 1'b1;
			OTP_MODE <= 1'b0;
			SEC_FLAGS <= 8'h00;
			CMD_OPCODE <= 8'h00;
			CMD_STROBE <= 1'b0;
			CMD_REFUSED <= 1'b0;
		end
		else
		begin
			sck_s1 <= SCK;
			sck_s2 <= sck_s1;
			sck_d <= sck_s2;
			cs_s1 <= CS_N;
			cs_s2 <= cs_s1;
			cs_d <= cs_s2;
			si_s1 <= SI;
			si_s2 <= si_s1;
			fl_s1 <= FACTORY_LOCK;
			factory <= fl_s1;
			SEC_FLAGS <= sec_value;
			CMD_STROBE <= 1'b0;
			CMD_REFUSED <= 1'b0;
			otp_wr <= 1'b0;
			if (cs_s2)
			begin
				bit_cnt <= 3'h0;
				byte_cnt <= 3'h0;
				phase <= ST_OP;
				load_pending <= 1'b0;
				SO_OE_N <= 1'b1;
				// Mode and lock changes take effect when the frame closes
				if (cs_rise && bit_cnt == 3'h0)
				begin
					if (byte_cnt == `BYTES_OP)
					begin
						if (opcode == `OP_ENTER_OTP)
							OTP_MODE <= 1'b1;
						if (opcode == `OP_EXIT_OTP)
							OTP_MODE <= 1'b0;
						if (opcode == `OP_WREN)
							wel <= 1'b1;
						if (opcode == `OP_WRDI)
							wel <= 1'b0;
					end
				end
				// Only set, never cleared; no enable needed
				if (cs_rise && opcode == `OP_WRITE_SEC &&
					phase == ST_DATA_IN)
				begin
					if (bit_cnt == 3'h0 && byte_cnt == `BYTES_WSEC)
						otp_lockdown_bit <= otp_lockdown_bit |
							wsec_data[`SEC_LOCKDOWN_BIT];
					else
						CMD_REFUSED <= 1'b1;
				end
				if (cs_rise && opcode == `OP_PROGRAM && OTP_MODE)
					wel <= 1'b0;
			end
			else
			begin
				if (load_pending)
				begin
					load_pending <= 1'b0;
					if (opcode == `OP_READ_SEC)
						out_shift <= sec_value;
					else if (opcode == `OP_READ_SFDP)
						out_shift <= sfdp_byte(addr[7:0]);
					else
						out_shift <= otp_in_range ? otp_rdata : `OTP_ERASED;
					if (opcode != `OP_READ_SEC)
						addr <= addr + 24'h000001;
				end
				if (sck_fall && phase == ST_DATA_OUT)
				begin
					SO <= out_shift[7];
					SO_OE_N <= 1'b0;
					out_shift <= {out_shift[6:0], 1'b0};
				end
				if (sck_rise)
				begin
					shift <= next_byte[6:0];
					bit_cnt <= bit_cnt + 3'h1;
				end
				if (sck_rise && bit_cnt == `BIT_LAST)
				begin
					if (byte_cnt != `BYTE_CNT_MAX)
						byte_cnt <= byte_cnt + 3'h1;
					case (phase)
						ST_OP:
						begin
							opcode <= next_byte;
							CMD_OPCODE <= next_byte;
							if (refuse)
							begin
								CMD_REFUSED <= 1'b1;
								phase <= ST_IGNORE;
							end
							else if (next_byte == `OP_READ_SEC)
							begin
								load_pending <= 1'b1;
								phase <= ST_DATA_OUT;
							end
							else if (next_byte == `OP_READ_SFDP ||
								(OTP_MODE && (next_byte == `OP_READ ||
								next_byte == `OP_PROGRAM)))
								phase <= ST_ADDR;
							else if (next_byte == `OP_WRITE_SEC)
								phase <= ST_DATA_IN;
							else if (next_byte == `OP_ENTER_OTP ||
								next_byte == `OP_EXIT_OTP ||
								next_byte == `OP_WREN ||
								next_byte == `OP_WRDI)
								phase <= ST_IGNORE;
							else
							begin
								// Main array work belongs to the core logic
								CMD_STROBE <= 1'b1;
								phase <= ST_IGNORE;
							end
						end
						ST_ADDR:
						begin
							addr <= {addr[15:0], next_byte};
							if (byte_cnt == `BYTE_ADDR_LAST)
							begin
								if (opcode == `OP_READ_SFDP)
									phase <= ST_DUMMY;
								else if (opcode == `OP_READ)
								begin
									load_pending <= 1'b1;
									phase <= ST_DATA_OUT;
								end
								else
									phase <= ST_DATA_IN;
							end
						end
						ST_DUMMY:
						begin
							load_pending <= 1'b1;
							phase <= ST_DATA_OUT;
						end
						ST_DATA_IN:
						begin
							if (opcode == `OP_WRITE_SEC)
								wsec_data <= next_byte;
							else
							begin
								// Bytes land as they arrive, not at frame end
								otp_wr <= otp_in_range & ~locked;
								otp_waddr <= addr[`OTP_AW-1:0];
								otp_wdata <= next_byte;
								addr <= addr + 24'h000001;
							end
						end
						ST_DATA_OUT:
							load_pending <= 1'b1;
						default:
							phase <= ST_IGNORE;
					endcase
				end
			end
		end
	end
endmodule // otp_access_ctrl

// *** core/otp_store.v ***
// Secured OTP byte storage, separate from the main array
`include "otp_access_regs.vh"

module otp_store (
	input wire clk,
	input wire wr_en,
	input wire [`OTP_AW-1:0] waddr,
	input wire [7:0] wdata,
	input wire [`OTP_AW-1:0] raddr,
	output wire [7:0] rdata
);
	reg [7:0] mem [0:`OTP_DEPTH-1];
	integer i;

	// Simulation starts from the erased state; silicon keeps its contents
	initial
	begin
		for (i = 0; i < `OTP_DEPTH; i = i + 1)
			mem[i] = `OTP_ERASED;
	end

	// Programming only clears bits, as in any flash cell
	always @(posedge clk)
	begin
		if (wr_en)
			mem[waddr] <= mem[waddr] & wdata;
	end

	assign rdata = mem[raddr];
endmodule // otp_store

// *** pkg/otp_access_regs.vh ***
// Constants for the secured OTP access controller
`ifndef OTP_ACCESS_REGS_VH
`define OTP_ACCESS_REGS_VH

// Instruction opcodes
`define OP_ENTER_OTP 8'hb1
`define OP_EXIT_OTP 8'hc1
`define OP_READ_SEC 8'h2b
`define OP_WRITE_SEC 8'h2f
`define OP_WRITE_SR1 8'h01
`define OP_WRITE_SR2 8'h31
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_PROGRAM 8'h02
`define OP_QPROGRAM 8'h32
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_READ_SFDP 8'h5a
`define OP_READ_SR1 8'h05
`define OP_READ_SR2 8'h35
`define OP_READ_ID 8'h9f
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_ERASE_CHIP1 8'hc7
`define OP_ERASE_CHIP2 8'h60

// Security flag layout
`define SEC_FACTORY_BIT 0
`define SEC_LOCKDOWN_BIT 1
`define SEC_RSVD_ZERO 6'h00

// OTP region: 4096 bits as 512 bytes
`define OTP_DEPTH 512
`define OTP_AW 9
`define OTP_ERASED 8'hff

// Frame bookkeeping
`define BIT_LAST 3'h7
`define BYTES_OP 3'h1
`define BYTES_WSEC 3'h2
`define BYTE_ADDR_LAST 3'h3
`define BYTE_CNT_MAX 3'h7

// Discoverable-parameter bytes around the quad-enable field
`define SFDP_ADDR_68 8'h68
`define SFDP_ADDR_69 8'h69
`define SFDP_ADDR_6A 8'h6a
`define SFDP_DATA_68 8'h19
`define SFDP_DATA_69 8'hf6
`define SFDP_QUAD_ENABLE_REQUIREMENT 3'h1
`define SFDP_HOLD_RST_DIS 1'h0
`define SFDP_LOW_6A 4'hc
`define SFDP_FILL 8'hff

`endif

// *** testbench/otp_access_props.sv ***
// Port assertions for the OTP access controller
module otp_access_props (
	input wire CORE_CLK,
	input wire RST,
	input wire CS_N,
	input wire FACTORY_LOCK,
	input wire SO_OE_N,
	input wire OTP_MODE,
	input wire [7:0] SEC_FLAGS,
	input wire [7:0] CMD_OPCODE,
	input wire CMD_STROBE,
	input wire CMD_REFUSED
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	// Sync plus register gives three edges; six leaves margin
	sequence cs_idle;
		CS_N [*6];
	endsequence
	rsvd_zero_a: assert property (SEC_FLAGS[7:2] == 6'h00)
		else $error("reserved flag bits set");
	factory_follow_a: assert property (
		$rose(FACTORY_LOCK) |-> ##[1:4] SEC_FLAGS[0])
		else $error("factory flag late");
	lock_sticky_a: assert property (SEC_FLAGS[1] |=> SEC_FLAGS[1])
		else $error("lockdown cleared");
	lock_outside_a: assert property ($rose(SEC_FLAGS[1]) |-> !OTP_MODE)
		else $error("lockdown set in otp mode");
	mode_idle_a: assert property (
		$changed(OTP_MODE) |-> CS_N && $past(CS_N))
		else $error("mode changed in frame");
	so_release_a: assert property (cs_idle |-> SO_OE_N)
		else $error("output driven while idle");
	no_write_fwd_a: assert property (CMD_STROBE && OTP_MODE |->
		!(CMD_OPCODE inside {8'h01, 8'h31, 8'h2f, 8'h02, 8'h32,
		8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60}))
		else $error("write forwarded in otp mode");
	pulse_excl_a: assert property (!(CMD_STROBE && CMD_REFUSED))
		else $error("strobe and refuse together");
endmodule // otp_access_props

bind otp_access_ctrl otp_access_props i_props (.CORE_CLK, .RST, .CS_N,
	.FACTORY_LOCK, .SO_OE_N, .OTP_MODE, .SEC_FLAGS, .CMD_OPCODE,
	.CMD_STROBE, .CMD_REFUSED);

// *** testbench/spi_host_model.sv ***
// Serial host model sending mode 0 frames, MSB first
module spi_host_model (
	input wire clk,
	input wire so,
	output reg sck,
	output reg cs_n,
	output reg si,
	output reg [63:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rx = 64'h0;
	end
	// Enter, exit and lock commands all ride on these frames
	task start;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// Eight cycles a phase keeps SCK inside the synchroniser limit
	task xfer(input [7:0] b);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
		begin
			si <= b[i];
			repeat (8) @(posedge clk);
			rx <= {rx[62:0], so};
			sck <= 1'b1;
			repeat (8) @(posedge clk);
			sck <= 1'b0;
		end
	endtask
	task stop;
		repeat (8) @(posedge clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (16) @(posedge clk);
	endtask
endmodule // spi_host_model

// *** testbench/tb_otp_access_ctrl.sv ***
// Self-checking bench for the OTP access controller
module tb_otp_access_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic factory_lock = 1'b0;
	int n_ref = 0;
	int n_stb = 0;
	int n_oe = 0;
	int ref0, stb0, oe0;
	wire sck, cs_n, si, so, so_oe_n, otp_mode, cmd_strobe, cmd_refused;
	wire [7:0] sec_flags, cmd_opcode;
	wire [63:0] rx;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	// Row: opcode, then expected mode, refusal and strobe
	logic [10:0] rows [13] = '{{8'hb1, 3'b100}, {8'h01, 3'b110},
		{8'h31, 3'b110}, {8'h2f, 3'b110}, {8'h20, 3'b110},
		{8'h52, 3'b110}, {8'hd8, 3'b110}, {8'hc7, 3'b110},
		{8'h60, 3'b110}, {8'h32, 3'b110}, {8'h9f, 3'b101},
		{8'hc1, 3'b000}, {8'h01, 3'b001}};
	otp_access_ctrl i_dut (.CORE_CLK(core_clk), .RST(rst), .SCK(sck),
		.CS_N(cs_n), .SI(si), .FACTORY_LOCK(factory_lock), .SO(so),
		.SO_OE_N(so_oe_n), .OTP_MODE(otp_mode), .SEC_FLAGS(sec_flags),
		.CMD_OPCODE(cmd_opcode), .CMD_STROBE(cmd_strobe),
		.CMD_REFUSED(cmd_refused));
	spi_host_model i_host (.clk(core_clk), .so(so), .sck(sck),
		.cs_n(cs_n), .si(si), .rx(rx));
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cmd_refused === 1'b1)
			n_ref <= n_ref + 1;
		if (cmd_strobe === 1'b1)
			n_stb <= n_stb + 1;
		if (so_oe_n === 1'b0)
			n_oe <= n_oe + 1;
		if (cyc == 30000)
		begin
			err_total++;
			give_verdict;
		end
	end
	task give_verdict;
		if (err_total == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		if (got !== exp)
			err_total++;
	endtask
	task cmd(input int n, input logic [63:0] d);
		int i;
		ref0 = n_ref;
		stb0 = n_stb;
		oe0 = n_oe;
		i_host.start;
		for (i = 0; i < n; i++)
			i_host.xfer(d[8 * (n - 1 - i) +: 8]);
		i_host.stop;
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk({6'h00, otp_mode, so_oe_n}, 8'h01);
		chk(sec_flags, 8'h00);
		for (int r = 0; r < 13; r++)
		begin
			cmd(1, {56'h0, rows[r][10:3]});
			chk({5'h00, otp_mode, n_ref != ref0, n_stb != stb0},
				{5'h00, rows[r][2:0]});
			chk(cmd_opcode, rows[r][10:3]);
		end
		factory_lock <= 1'b1;
		cmd(3, 64'h2b0000);
		chk(rx[15:8], 8'h01);
		chk(rx[7:0], 8'h01);
		chk({6'h00, so_oe_n, n_oe != oe0}, 8'h03);
		// Factory lock would block programming below, so drop it again
		factory_lock <= 1'b0;
		cmd(7, 64'h5a000069000000);
		chk(rx[15:8], 8'hf6);
		chk(rx[7:0], 8'h1c);
		cmd(1, 64'hb1);
		cmd(1, 64'h06);
		cmd(5, 64'h020001ffa5);
		cmd(6, 64'h030001ff0000);
		chk(rx[15:8], 8'ha5);
		chk(rx[7:0], 8'hff);
		cmd(1, 64'hc1);
		cmd(3, 64'h2fff00);
		chk({7'h00, n_ref != ref0}, 8'h01);
		chk(sec_flags, 8'h00);
		cmd(2, 64'h2fff);
		chk(sec_flags, 8'h02);
		cmd(1, 64'hb1);
		cmd(1, 64'h06);
		chk({7'h00, n_ref != ref0}, 8'h01);
		cmd(5, 64'h020001ff00);
		chk({7'h00, n_ref != ref0}, 8'h01);
		cmd(6, 64'h030001ff0000);
		chk(rx[15:8], 8'ha5);
		cmd(1, 64'hc1);
		cmd(2, 64'h2f00);
		chk({6'h00, otp_mode, sec_flags[1]}, 8'h01);
		give_verdict;
	end
endmodule // tb_otp_access_ctrl
